// ===== asr_register_bank.sv
// asr_register_bank: serial write frame decode, control register, read source select.
// assumes: serial pins come from outside and are synchronised here; converter core
// signals share core_clk_in.
`default_nettype none
module asr_register_bank (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // serial link pins, asynchronous to core_clk_in
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic din_in,
  input wire logic sleep_n_in,
  // serial outputs
  output logic dout_out,
  output logic din_out,
  output logic din_oe_n_out,
  // converter core, same clock
  input wire logic [11:0] conv_data_in,
  input wire logic conv_done_in,
  input wire logic cal_done_in,
  output asr_pkg::asr_core_req_t core_req_out,
  output logic [2:0] power_mode_out,
  output logic [13:0] cal_word_out
);
  import asr_pkg::*;

  // two-flop synchronisers; only the second stage is read by logic
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic sclk_prev_q;
  logic sleep_meta_q;
  logic sleep_n_q;
  // reset to the idle pin levels: sync_n high, sclk low, so no false frame or edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin_meta_q <= 3'h4;
      pin_sync_q <= 3'h4;
      sclk_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= {sync_n_in, sclk_in, din_in};
      pin_sync_q <= pin_meta_q;
      sclk_prev_q <= pin_sync_q[1];
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sleep_meta_q <= 1'b1;
      sleep_n_q <= 1'b1;
    end else begin
      sleep_meta_q <= sleep_n_in;
      sleep_n_q <= sleep_meta_q;
    end
  end

  // sleep is followed at all times, inside a frame too
  wire sync_n_s = pin_sync_q[2];
  wire sclk_s = pin_sync_q[1];
  wire din_s = pin_sync_q[0];
  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;

  // frame tracking
  logic frame_q;
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_in_q;
  logic [15:0] shift_out_q;
  logic commit_q;
  wire frame_open = ~sync_n_s & ~frame_q;
  wire take_bit = frame_q & ~sync_n_s & sclk_rise & (bit_cnt_q != FRAME_LAST);
  wire last_bit = take_bit & (bit_cnt_q == FRAME_LAST - 5'h01);

  asr_ctrl_t ctrl_q;
  logic conv_busy_q;
  logic cal_busy_q;
  logic [15:0] read_word;
  wire [13:0] test_word;
  wire [13:0] cal_words [CAL_REGS];

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= ~sync_n_s;
    end
  end

  // a frame cut short leaves the count behind; sync_n high clears it
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      bit_cnt_q <= 5'h00;
    end else if (sync_n_s | frame_open) begin
      bit_cnt_q <= 5'h00;
    end else if (take_bit) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      shift_in_q <= 16'h0000;
    end else if (take_bit) begin
      shift_in_q <= {shift_in_q[14:0], din_s};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      shift_out_q <= 16'h0000;
    end else if (frame_open) begin
      shift_out_q <= read_word;
    end else if (frame_q & ~sync_n_s & sclk_fall) begin
      shift_out_q <= {shift_out_q[14:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      commit_q <= 1'b0;
    end else begin
      commit_q <= last_bit;
    end
  end

  // decode of a completed frame
  wire [1:0] wr_target = shift_in_q[ADDR_MSB:ADDR_LSB];
  wire [13:0] wr_data = shift_in_q[DATA_BITS-1:0];
  wire wr_test = commit_q & (wr_target == TGT_TEST);
  wire wr_cal = commit_q & (wr_target == TGT_CAL);
  wire wr_ctrl = commit_q & (wr_target == TGT_CTRL);
  // TGT_NONE raises none of the strobes above
  wire [1:0] cal_sel = {ctrl_q.calibration_choice_hi, ctrl_q.calibration_choice_lo};
  wire [1:0] rd_sel = {ctrl_q.read_source_hi, ctrl_q.read_source_lo};
  asr_ctrl_t wr_ctrl_val;
  assign wr_ctrl_val = asr_ctrl_t'(wr_data);

  asr_word_reg u_test (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .wr_en_in(wr_test),
    .wr_data_in(wr_data),
    .word_out(test_word)
  );

  genvar gi;
  generate
    for (gi = 0; gi < CAL_REGS; gi++) begin : g_cal
      asr_word_reg u_cal (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .wr_en_in(wr_cal & (cal_sel == 2'(gi))),
        .wr_data_in(wr_data),
        .word_out(cal_words[gi])
      );
    end
  endgenerate

  // a read cycle ends when a full frame has been clocked
  wire read_done = commit_q;
  wire conv_req = wr_ctrl & wr_ctrl_val.software_convert_start;
  wire cal_req = wr_ctrl & wr_ctrl_val.calibration_go;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_q <= asr_ctrl_t'(CTRL_RESET);
    end else if (wr_ctrl) begin
      // every frame is also a read; a control write re-arms mode 1 itself
      ctrl_q <= wr_ctrl_val;
    end else begin
      if (read_done) begin
        ctrl_q.interface_mode <= 1'b0;
      end
      if (conv_done_in) begin
        ctrl_q.software_convert_start <= 1'b0;
      end
      if (cal_done_in) begin
        ctrl_q.calibration_go <= 1'b0;
      end
    end
  end

  // busy flags: a new start in the done cycle wins over the clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      conv_busy_q <= 1'b0;
      cal_busy_q <= 1'b0;
    end else begin
      conv_busy_q <= conv_req | (conv_busy_q & ~conv_done_in);
      cal_busy_q <= cal_req | (cal_busy_q & ~cal_done_in);
    end
  end

  // read source selection
  wire [15:0] conv_word = {CONV_PAD, conv_data_in};
  // status word fields, bit 15 down to bit 0
  wire busy_any = conv_busy_q | cal_busy_q;
  wire [1:0] stat_pm = {ctrl_q.power_manage_hi, ctrl_q.power_manage_lo};
  wire [3:0] stat_cal = {ctrl_q.calibration_kind, cal_sel, cal_busy_q};
  wire [15:0] stat_word = {1'b0, busy_any, 4'h0, stat_pm, STAT_MARK,
    ctrl_q.interface_mode, 1'b0, stat_cal};
  always_comb begin
    case (rd_sel)
      SRC_CONV: begin
        read_word = conv_word;
      end
      SRC_TEST: begin
        read_word = {REG_PAD, test_word};
      end
      SRC_CAL: begin
        read_word = {REG_PAD, cal_words[cal_sel]};
      end
      SRC_STAT: begin
        read_word = stat_word;
      end
      default: begin
        read_word = conv_word;
      end
    endcase
  end

  // registered outputs
  asr_core_req_t core_req_q;
  logic [2:0] power_mode_q;
  logic dout_q;
  logic din_oe_n_q;
  logic [13:0] cal_word_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      core_req_q <= '0;
    end else begin
      core_req_q.convert_start <= conv_req;
      core_req_q.cal_start <= cal_req;
      // all-zero type is the full internal calibration
      core_req_q.cal_type <= {ctrl_q.calibration_kind, cal_sel};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      power_mode_q <= 3'h4;
    end else begin
      power_mode_q <= {sleep_n_q, stat_pm};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dout_q <= 1'b0;
    end else begin
      dout_q <= shift_out_q[FRAME_BITS-1];
    end
  end

  // mode 1 turns din around only inside a frame, never while idle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      din_oe_n_q <= 1'b1;
    end else begin
      din_oe_n_q <= ~(ctrl_q.interface_mode & frame_q & ~sync_n_s);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cal_word_q <= WORD_RESET;
    end else begin
      cal_word_q <= cal_words[cal_sel];
    end
  end

  assign dout_out = dout_q;
  assign din_out = dout_q;
  assign din_oe_n_out = din_oe_n_q;
  assign core_req_out = core_req_q;
  assign power_mode_out = power_mode_q;
  assign cal_word_out = cal_word_q;
endmodule
`default_nettype wire

// ===== asr_pkg.sv
// asr_pkg: shared constants and types for the serial register bank.
// assumes: included first in compile order; no other dependencies.
`default_nettype none
package asr_pkg;
  // frame layout, most significant bit first
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned DATA_BITS = 14;
  localparam int unsigned RESULT_BITS = 12;
  localparam logic [4:0] FRAME_LAST = 5'h10;
  localparam int unsigned ADDR_MSB = 15;
  localparam int unsigned ADDR_LSB = 14;
  localparam int unsigned CAL_REGS = 4;

  // write target codes
  localparam logic [1:0] TGT_NONE = 2'h0;
  localparam logic [1:0] TGT_TEST = 2'h1;
  localparam logic [1:0] TGT_CAL = 2'h2;
  localparam logic [1:0] TGT_CTRL = 2'h3;

  // read source codes
  localparam logic [1:0] SRC_CONV = 2'h0;
  localparam logic [1:0] SRC_TEST = 2'h1;
  localparam logic [1:0] SRC_CAL = 2'h2;
  localparam logic [1:0] SRC_STAT = 2'h3;

  // reset values
  localparam logic [13:0] CTRL_RESET = 14'h0000;
  localparam logic [13:0] WORD_RESET = 14'h0000;

  // read word fixed fields: status word mark, conversion and register padding
  localparam logic [1:0] STAT_MARK = 2'h3;
  localparam logic [3:0] CONV_PAD = 4'h0;
  localparam logic [1:0] REG_PAD = 2'h0;

  // control register layout, bit 13 down to bit 0
  typedef struct packed {
    logic [3:0] zero;
    logic power_manage_hi;
    logic power_manage_lo;
    logic read_source_hi;
    logic read_source_lo;
    logic interface_mode;
    logic software_convert_start;
    logic calibration_kind;
    logic calibration_choice_hi;
    logic calibration_choice_lo;
    logic calibration_go;
  } asr_ctrl_t;

  // request bundle to the converter core
  typedef struct packed {
    logic convert_start;
    logic cal_start;
    logic [2:0] cal_type;
  } asr_core_req_t;
endpackage
`default_nettype wire

// ===== asr_word_reg.sv
// asr_word_reg: one 14-bit read/write storage word with write enable.
// assumes: same clock and synchronous reset as the register bank.
`default_nettype none
module asr_word_reg (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // write side
  input wire logic wr_en_in,
  input wire logic [13:0] wr_data_in,
  // stored value
  output logic [13:0] word_out
);
  import asr_pkg::*;
  logic [13:0] word_q;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      word_q <= WORD_RESET;
    end else if (wr_en_in) begin
      word_q <= wr_data_in;
    end
  end
  assign word_out = word_q;
endmodule
`default_nettype wire

// ===== asr_monitor.sv
// asr_monitor: port checks for the serial register bank.
// assumes: bound onto asr_register_bank; one clock domain.
`default_nettype none
module asr_monitor (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // watched ports
  input wire logic sync_n_in,
  input wire logic sleep_n_in,
  input wire logic din_oe_n_out,
  input wire asr_pkg::asr_core_req_t core_req_out,
  input wire logic [2:0] power_mode_out,
  input wire logic [13:0] cal_word_out
);
  import asr_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // eight quiet cycles outlast the pin synchronisers and the commit
  sequence s_idle;
    sync_n_in [*8];
  endsequence
  a_conv_one_shot: assert property (core_req_out.convert_start |=>
    !core_req_out.convert_start) else $error("convert start too long");
  a_cal_one_shot: assert property (core_req_out.cal_start |=>
    !core_req_out.cal_start) else $error("cal start too long");
  a_req_in_frame: assert property (s_idle |->
    !core_req_out.convert_start && !core_req_out.cal_start) else $error("start outside frame");
  a_reset_clear: assert property ($past(rst_in) |-> core_req_out == 5'h0 &&
    cal_word_out == 14'h0 && din_oe_n_out) else $error("reset values wrong");
  a_oe_frame_only: assert property (s_idle |-> din_oe_n_out)
    else $error("din driven outside frame");
  a_sleep_follow: assert property ($fell(sleep_n_in) |-> ##[1:8]
    !power_mode_out[2]) else $error("sleep pin not followed");
  a_pm_hold: assert property (s_idle |=> $stable(power_mode_out[1:0]))
    else $error("power bits moved without write");
  a_caltype_hold: assert property (s_idle |=> $stable(core_req_out.cal_type))
    else $error("cal type moved without write");
  a_calword_hold: assert property (s_idle |=> $stable(cal_word_out))
    else $error("cal word moved without write");
endmodule
`default_nettype wire

// ===== asr_host.sv
// asr_host: serial host model, full 16-bit or cut-short frames.
// assumes: sclk idles low and runs only inside frames, 160 ns period.
`default_nettype none
module asr_host (
  // serial pins
  output logic sclk_out,
  output logic sync_n_out,
  output logic din_drv_out,
  input wire logic dout_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b0;
    sync_n_out = 1'b1;
    din_drv_out = 1'b0;
  end
  // n below 16 gives a partial frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0;
    sync_n_out = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      din_drv_out = w[i];
      #80 sclk_out = 1'b1;
      #79 r[i] = dout_in;
      #1 sclk_out = 1'b0;
    end
    #80 sync_n_out = 1'b1;
    // released line has no pull: show the inverse
    din_drv_out = ~din_drv_out;
    #80;
  endtask
endmodule
`default_nettype wire

// ===== tb_asr_register_bank.sv
// tb_asr_register_bank: directed scenarios for the serial register bank.
// assumes: asr_host plays the serial host; core side driven here.
`default_nettype none
module tb_asr_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  import asr_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic sleep_n_in = 1'b1;
  logic conv_done_in = 1'b0;
  logic cal_done_in = 1'b0;
  logic [11:0] conv_data_in = 12'habc;
  logic sclk, sync_n, host_din, dout, din_out, din_oe_n;
  wire din_w;
  asr_core_req_t core_req;
  logic [2:0] power_mode;
  logic [13:0] cal_word;
  logic [15:0] r;
  logic saw_oe = 1'b0;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 core_clk_in = ~core_clk_in;
  assign din_w = (din_oe_n | ~sync_n) ? host_din : din_out;
  asr_host i_asr_host (.sclk_out(sclk), .sync_n_out(sync_n), .din_drv_out(host_din),
    .dout_in(dout));
  asr_register_bank i_asr_register_bank (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .sclk_in(sclk), .sync_n_in(sync_n), .din_in(din_w), .sleep_n_in(sleep_n_in),
    .dout_out(dout), .din_out(din_out), .din_oe_n_out(din_oe_n),
    .conv_data_in(conv_data_in), .conv_done_in(conv_done_in), .cal_done_in(cal_done_in),
    .core_req_out(core_req), .power_mode_out(power_mode), .cal_word_out(cal_word));
  task automatic final_report();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (din_oe_n === 1'b0) saw_oe = 1'b1;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // host keeps control bits 13:10 at zero in every write
  task automatic wr(input logic [15:0] w);
    i_asr_host.xfer(w, 16, r);
  endtask
  task automatic done(input logic cal);
    @(posedge core_clk_in);
    cal_done_in <= cal;
    conv_done_in <= ~cal;
    @(posedge core_clk_in);
    cal_done_in <= 1'b0;
    conv_done_in <= 1'b0;
  endtask
  task automatic t_reset();
    wr(16'h0000);
    chk(r, {CONV_PAD, 12'habc});
  endtask
  task automatic t_test();
    wr(16'h5234);
    wr(16'hc040);
    wr(16'h3fff);
    chk(r, {REG_PAD, 14'h1234});
    i_asr_host.xfer(16'h7fff, 10, r);
    wr(16'h0000);
    chk(r, 16'h1234);
  endtask
  task automatic t_cal();
    wr(16'hc084);
    wr(16'h8155);
    chk({2'h0, cal_word}, 16'h0155);
    wr(16'h0000);
    chk(r, 16'h0155);
    wr(16'hc082);
    chk({2'h0, cal_word}, 16'h0000);
  endtask
  task automatic t_status();
    wr(16'hc1d0);
    chk({13'h0, power_mode}, 16'h0005);
    wr(16'h0000);
    chk(r & 16'h43c0, 16'h41c0);
    done(1'b0);
    wr(16'h0000);
    chk(r & 16'h43c0, 16'h01c0);
    @(posedge core_clk_in);
    sleep_n_in <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    chk({13'h0, power_mode}, 16'h0001);
    sleep_n_in <= 1'b1;
  endtask
  task automatic t_calgo();
    wr(16'hc0c1);
    chk({13'h0, core_req.cal_type}, 16'h0000);
    wr(16'h0000);
    chk(r & 16'h4001, 16'h4001);
    done(1'b1);
    wr(16'h0000);
    chk(r & 16'h4001, 16'h0000);
    wr(16'hc0cf);
    chk({13'h0, core_req.cal_type}, 16'h0007);
    done(1'b1);
  endtask
  // mode 1 needs the bit in every write
  task automatic t_mode();
    wr(16'hc0e0);
    saw_oe = 1'b0;
    wr(16'h0000);
    chk(r & 16'h0020, 16'h0020);
    chk({15'h0, saw_oe}, 16'h0001);
    wr(16'h0000);
    chk(r & 16'h0020, 16'h0000);
  endtask
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    t_reset();
    t_test();
    t_cal();
    t_status();
    t_calgo();
    t_mode();
    final_report();
  end
endmodule
bind asr_register_bank asr_monitor i_asr_monitor (.core_clk_in(core_clk_in),
  .rst_in(rst_in), .sync_n_in(sync_n_in), .sleep_n_in(sleep_n_in),
  .din_oe_n_out(din_oe_n_out), .core_req_out(core_req_out),
  .power_mode_out(power_mode_out), .cal_word_out(cal_word_out));
`default_nettype wire
